//--- core/ewsb_bridge.v
`timescale 1ns/1ps
`include "ewsb_defs.vh"
// Redriving bridge with expansion wait-state generator
module ewsb_bridge #(
   parameter ADDR_W = 20,
   parameter DATA_W = 8
) (
   input wire ref_clk,
   input wire reset,
   input wire clkEn,
   // System side, outward group then inward group
   input wire [ADDR_W-1:0] sysAddr,
   input wire sysDmaOwnsBus,
   input wire [3:0] sysDmaAcknowledgesN,
   input wire sysMemReadStrobeN,
   input wire sysMemWriteStrobeN,
   input wire sysPortReadStrobeN,
   input wire sysPortWriteStrobeN,
   input wire sysAle,
   input wire sysTermCount,
   input wire sysChanReset,
   input wire sysRefresh,
   input wire [DATA_W-1:0] sysDataIn,
   output reg [DATA_W-1:0] sysDataOut,
   output reg sysDataOe,
   output reg [5:0] sysInterruptRequests,
   output reg [2:0] sysDmaRequests,
   output reg sysChannelReadyLine,
   output reg sysChannelCheckErrorN,
   // Segment switch, 1 = off
   input wire [3:0] segSwitch,
   // Expansion side
   output reg [ADDR_W-1:0] expAddr,
   output reg expDmaOwnsBus,
   output reg [3:0] expDmaAcknowledgesN,
   output reg expMemReadStrobeN,
   output reg expMemWriteStrobeN,
   output reg expPortReadStrobeN,
   output reg expPortWriteStrobeN,
   output reg expAle,
   output reg expClk,
   output reg expTermCount,
   output reg expChanReset,
   output reg [DATA_W-1:0] expDataOut,
   output reg expDataOe,
   input wire [DATA_W-1:0] expDataIn,
   input wire [5:0] expInterruptRequests,
   input wire [2:0] expDmaRequests,
   input wire expChannelReadyLine,
   input wire expChannelCheckErrorN,
   output reg waitActive
);
   localparam ST_IDLE = 3'b001;
   localparam ST_WAIT = 3'b010;
   localparam ST_DONE = 3'b100;

   wire [5:0] irqS;
   wire [2:0] drqS;
   wire [3:0] swS;
   wire rdyS;
   wire chkS;
   wire [DATA_W-1:0] dataS;
   reg [2:0] state_r;
   reg [2:0] state_nxt;
   reg [1:0] cnt_r;
   reg [1:0] cnt_nxt;
   reg clkDiv_r;
   reg qualify;
   wire [3:0] seg;
   wire memStrobe;

   // Wait-state scheme in brief:
   // Qualify a memory cycle on the sampled strobes and address.
   // Drop system ready for one clock, then let it follow the far side.
   // A slow option adapter can still stretch the cycle through its own ready.
   // Its hold arrives three clocks late, after the sync and the register.
   // One wait per strobe; the machine re-arms only once both strobes rise.
   // Port cycles never qualify, as the compare looks at memory strobes only.
   // Refresh is a separate qualifier, so refresh never costs a wait.
   // Segment F stays exempt whatever the switch says.
   // All state holds while clkEn is low, so an idle enable never adds a wait.

   // Inward pins come from the far cable end, so synchronise
   ewsb_sync #(.WIDTH(6 + 3 + 4 + 1 + 1 + DATA_W)) uSync (
      .ref_clk(ref_clk),
      .reset(reset),
      .clkEn(clkEn),
      .asyncIn({expInterruptRequests, expDmaRequests, segSwitch,
         expChannelReadyLine, expChannelCheckErrorN, expDataIn}),
      .syncOut({irqS, drqS, swS, rdyS, chkS, dataS})
   );
   // Switch is synchronised too: a flip mid-cycle must not glitch the compare.
   // Limitation: a new setting takes two clocks to apply.
   // Read data is sampled late; the far end holds it for the whole strobe.
   // Trade-off: one shared synchroniser keeps the inward paths in step.

   assign seg = sysAddr[`EWSB_SEG_HI:`EWSB_SEG_LO];
   assign memStrobe = ~sysMemReadStrobeN | ~sysMemWriteStrobeN;

   // Switch reads 1 = off; inverted value is the first expansion segment
   always @* begin
      qualify = memStrobe & ~sysRefresh
         & (seg >= ~swS)
         & (seg != `EWSB_SEG_F);
   end
   // Compare is unsigned on the four segment bits.
   // Switch all on reads zero, so the limit is F and nothing waits.
   // Switch all off reads F, so every segment from 0 to E waits.
   // Option ROM is plain memory here; no type decode is needed.

   // One wait per strobe; DONE holds until both memory strobes rise
   always @* begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      case (state_r)
         ST_IDLE: begin
            if (qualify) begin
               state_nxt = ST_WAIT;
               cnt_nxt = `EWSB_WAIT_CLKS;
            end
         end
         ST_WAIT: begin
            if (cnt_r == 2'h1) begin
               state_nxt = ST_DONE;
            end
            cnt_nxt = cnt_r - 2'h1;
         end
         ST_DONE: begin
            if (!memStrobe) begin
               state_nxt = ST_IDLE;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
            cnt_nxt = 2'h0;
         end
      endcase
   end

   // State register; reset puts the machine idle with no wait pending.
   // Freezing on clkEn keeps the wait length counted in enabled clocks.
   always @(posedge ref_clk) begin
      if (reset) begin
         state_r <= ST_IDLE;
         cnt_r <= 2'h0;
      end else if (clkEn) begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // Outward redrive, registered; oscillator is not forwarded
   always @(posedge ref_clk) begin
      if (reset) begin
         expAddr <= {ADDR_W{1'b0}};
         expDmaOwnsBus <= 1'b0;
         expDmaAcknowledgesN <= 4'hf;
         expMemReadStrobeN <= 1'b1;
         expMemWriteStrobeN <= 1'b1;
         expPortReadStrobeN <= 1'b1;
         expPortWriteStrobeN <= 1'b1;
         expAle <= 1'b0;
         expClk <= 1'b0;
         expTermCount <= 1'b0;
         expChanReset <= 1'b1;
         expDataOut <= {DATA_W{1'b0}};
         expDataOe <= 1'b0;
         clkDiv_r <= 1'b0;
      end else if (clkEn) begin
         expAddr <= sysAddr;
         expDmaOwnsBus <= sysDmaOwnsBus;
         expDmaAcknowledgesN <= sysDmaAcknowledgesN;
         expMemReadStrobeN <= sysMemReadStrobeN;
         expMemWriteStrobeN <= sysMemWriteStrobeN;
         expPortReadStrobeN <= sysPortReadStrobeN;
         expPortWriteStrobeN <= sysPortWriteStrobeN;
         expAle <= sysAle;
         clkDiv_r <= ~clkDiv_r;
         expClk <= clkDiv_r; // Channel clock copy, half rate
         expTermCount <= sysTermCount;
         expChanReset <= sysChanReset;
         expDataOut <= sysDataIn;
         expDataOe <= ~sysMemWriteStrobeN | ~sysPortWriteStrobeN;
      end
   end

   // Inward redrive; ready merges device hold with our wait
   // Ready uses the next state so the wait shows on the qualifying edge.
   // Hazard: a registered copy of state_r would add one clock of delay.
   // Data enable toward the system follows the read strobes only.
   // Interrupt, request and check lines are copied without any filtering.
   // Check stays active low, as on the channel.
   // waitActive mirrors the bridge's own hold, not the far device's.
   always @(posedge ref_clk) begin
      if (reset) begin
         sysInterruptRequests <= 6'h00;
         sysDmaRequests <= 3'h0;
         sysChannelReadyLine <= 1'b1;
         sysChannelCheckErrorN <= 1'b1;
         sysDataOut <= {DATA_W{1'b0}};
         sysDataOe <= 1'b0;
         waitActive <= 1'b0;
      end else if (clkEn) begin
         sysInterruptRequests <= irqS;
         sysDmaRequests <= drqS;
         sysChannelCheckErrorN <= chkS;
         sysChannelReadyLine <= rdyS & (state_nxt != ST_WAIT);
         waitActive <= (state_nxt == ST_WAIT);
         sysDataOut <= dataS;
         sysDataOe <= ~sysMemReadStrobeN | ~sysPortReadStrobeN;
      end
   end
endmodule // ewsb_bridge

//--- core/ewsb_defs.vh
`ifndef EWSB_DEFS_VH
`define EWSB_DEFS_VH
`define EWSB_SEG_HI 19
`define EWSB_SEG_LO 16
`define EWSB_SEG_F 4'hf
`define EWSB_WAIT_CLKS 2'h1
`endif

//--- core/ewsb_sync.v
`timescale 1ns/1ps
// Two-flop synchroniser for pin-level inputs
module ewsb_sync #(
   parameter WIDTH = 1
) (
   input wire ref_clk,
   input wire reset,
   input wire clkEn,
   input wire [WIDTH-1:0] asyncIn,
   output reg [WIDTH-1:0] syncOut
);
   reg [WIDTH-1:0] meta_r;

   // First stage feeds only the second
   always @(posedge ref_clk) begin
      if (reset) begin
         meta_r <= {WIDTH{1'b0}};
         syncOut <= {WIDTH{1'b0}};
      end else if (clkEn) begin
         meta_r <= asyncIn;
         syncOut <= meta_r;
      end
   end
endmodule // ewsb_sync

//--- tb/ewsb_bridge_props.sv
`timescale 1ns/1ps
// Wait-state timing and redrive checks at the bridge ports
module ewsb_bridge_props (
   input wire ref_clk,
   input wire reset,
   input wire [19:0] sysAddr,
   input wire sysMemReadStrobeN,
   input wire sysMemWriteStrobeN,
   input wire sysRefresh,
   input wire [3:0] segSwitch,
   input wire sysChannelReadyLine,
   input wire waitActive,
   input wire [19:0] expAddr,
   input wire expMemReadStrobeN,
   input wire expChannelReadyLine
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   // Switch must be settled, the bench only moves it while idle
   wire memLow = !(sysMemReadStrobeN && sysMemWriteStrobeN);
   wire [3:0] seg = sysAddr[19:16];
   wire segHit = seg >= ~segSwitch && seg != 4'hf;
   property p_wait; memLow && !$past(memLow) && !sysRefresh && segHit |=> !sysChannelReadyLine && waitActive; endproperty
   a_wait: assert property (p_wait) else $error("wait missing");
   property p_once; waitActive |=> !waitActive; endproperty
   a_once: assert property (p_once) else $error("wait too long");
   property p_ref; memLow && sysRefresh |=> !waitActive; endproperty
   a_ref: assert property (p_ref) else $error("refresh waited");
   property p_segf; memLow && seg == 4'hf |=> !waitActive; endproperty
   a_segf: assert property (p_segf) else $error("segment f waited");
   property p_low; memLow && seg < ~segSwitch |=> !waitActive; endproperty
   a_low: assert property (p_low) else $error("system segment waited");
   property p_addr; expAddr == $past(sysAddr); endproperty
   a_addr: assert property (p_addr) else $error("address not redriven");
   property p_strb; expMemReadStrobeN == $past(sysMemReadStrobeN); endproperty
   a_strb: assert property (p_strb) else $error("strobe not redriven");
   property p_rdy; $past(!expChannelReadyLine, 3) |-> !sysChannelReadyLine; endproperty
   a_rdy: assert property (p_rdy) else $error("slow ready lost");
endmodule // ewsb_bridge_props
bind ewsb_bridge ewsb_bridge_props ewsb_bridge_props_inst (.ref_clk(ref_clk), .reset(reset),
   .sysAddr(sysAddr), .sysMemReadStrobeN(sysMemReadStrobeN),
   .sysMemWriteStrobeN(sysMemWriteStrobeN), .sysRefresh(sysRefresh), .segSwitch(segSwitch),
   .sysChannelReadyLine(sysChannelReadyLine), .waitActive(waitActive), .expAddr(expAddr),
   .expMemReadStrobeN(expMemReadStrobeN), .expChannelReadyLine(expChannelReadyLine));

//--- tb/ewsb_exp_model.sv
`timescale 1ns/1ps
// Expansion-side memory: echoes low address byte, may stretch
module ewsb_exp_model (
   input wire ref_clk,
   input wire slow,
   input wire expMemReadStrobeN,
   input wire [19:0] expAddr,
   output reg [7:0] expDataIn = 8'h00,
   output reg expChannelReadyLine = 1'b1
);
   reg [2:0] holdCnt_r = 3'h0;
   reg prevN_r = 1'b1;
   // Slow device holds ready low; released data toggles, never stale
   always @(posedge ref_clk) begin
      prevN_r <= expMemReadStrobeN;
      holdCnt_r <= (prevN_r && !expMemReadStrobeN && slow) ? 3'h4 : holdCnt_r - (holdCnt_r != 3'h0);
      expChannelReadyLine <= !(prevN_r && !expMemReadStrobeN && slow) && holdCnt_r <= 3'h1;
      expDataIn <= !expMemReadStrobeN ? expAddr[7:0] : ~expDataIn;
   end
endmodule // ewsb_exp_model

//--- tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   reg ref_clk = 1'b0;
   reg reset = 1'b1;
   reg [19:0] sysAddr = 20'h00000;
   reg rdN = 1'b1;
   reg wrN = 1'b1;
   reg sysRefresh = 1'b0;
   reg [3:0] segSwitch = 4'hf;
   reg [7:0] wData = 8'h00;
   reg [31:0] rnd = 32'h0;
   reg slow = 1'b0;
   reg [31:0] r;
   reg [3:0] sw;
   reg [3:0] seg;
   reg expW;
   integer seed = 51151;
   integer mismatches = 0;
   integer cmp_count = 0;
   integer i;
   wire [7:0] sysDataOut, expDataOut, expDataIn;
   wire sysChannelReadyLine, waitActive, expDataOe, expRdy, expRdN;
   wire [5:0] sysIrq;
   wire [2:0] sysDrq;
   wire sysChkN, sysOe;
   wire [19:0] expAddr;
   ewsb_bridge ewsb_bridge_inst (.ref_clk(ref_clk), .reset(reset), .clkEn(1'b1),
      .sysAddr(sysAddr), .sysDmaOwnsBus(rnd[0]), .sysDmaAcknowledgesN(rnd[7:4]),
      .sysMemReadStrobeN(rdN), .sysMemWriteStrobeN(wrN), .sysPortReadStrobeN(1'b1),
      .sysPortWriteStrobeN(1'b1), .sysAle(rnd[2]), .sysTermCount(rnd[3]),
      .sysChanReset(rnd[1]), .sysRefresh(sysRefresh), .sysDataIn(wData),
      .sysDataOut(sysDataOut), .sysDataOe(sysOe), .sysInterruptRequests(sysIrq),
      .sysDmaRequests(sysDrq),
      .sysChannelReadyLine(sysChannelReadyLine), .sysChannelCheckErrorN(sysChkN),
      .segSwitch(segSwitch), .expAddr(expAddr), .expDmaOwnsBus(), .expDmaAcknowledgesN(),
      .expMemReadStrobeN(expRdN), .expMemWriteStrobeN(), .expPortReadStrobeN(),
      .expPortWriteStrobeN(), .expAle(), .expClk(), .expTermCount(), .expChanReset(),
      .expDataOut(expDataOut), .expDataOe(expDataOe), .expDataIn(expDataIn),
      .expInterruptRequests(rnd[13:8]), .expDmaRequests(rnd[16:14]),
      .expChannelReadyLine(expRdy), .expChannelCheckErrorN(rnd[17]), .waitActive(waitActive));
   ewsb_exp_model ewsb_exp_model_inst (.ref_clk(ref_clk), .slow(slow),
      .expMemReadStrobeN(expRdN), .expAddr(expAddr), .expDataIn(expDataIn),
      .expChannelReadyLine(expRdy));
   task chk(input [7:0] seen, input [7:0] want, input [63:0] what);
      cmp_count = cmp_count + 1;
      if (seen !== want) begin
         mismatches = mismatches + 1;
         $display("Error %0s expected %h seen %h", what, want, seen);
      end
   endtask
   task final_report;
      $display("Compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial forever #20 ref_clk = ~ref_clk;
   // Run needs about 1500 clocks; allow ample margin
   initial begin
      #400000;
      mismatches = mismatches + 1;
      final_report;
   end
   // Sweep all segments under switch all-off, all-on and one random setting, then random cycles
   initial begin
      repeat (12) @(posedge ref_clk);
      reset <= 1'b0;
      for (i = 0; i < 160; i = i + 1) begin
         @(posedge ref_clk);
         r = $random(seed);
         if (i % 16 == 0) begin
            sw = (i == 0) ? 4'hf : (i == 16) ? 4'h0 : r[11:8];
            segSwitch <= sw;
            repeat (4) @(posedge ref_clk);
         end
         seg = (i < 48) ? i[3:0] : r[19:16];
         rnd <= r;
         sysAddr <= {seg, r[15:0]};
         sysRefresh <= (i >= 48) && r[20] && r[21];
         wData <= r[31:24];
         rdN <= r[22];
         wrN <= ~r[22];
         slow <= (i >= 48) && r[23];
         expW = !((i >= 48) && r[20] && r[21]) && seg != 4'hf && seg >= ~sw;
         @(posedge ref_clk);
         #1;
         chk(waitActive, expW, "wait");
         chk(sysChannelReadyLine, !expW, "ready");
         repeat (6) @(posedge ref_clk);
         #1;
         // Inward requests pass two sync flops and one register
         chk({2'h0, sysIrq}, {2'h0, r[13:8]}, "irq");
         chk({5'h00, sysDrq}, {5'h00, r[16:14]}, "drq");
         chk({7'h00, sysChkN}, {7'h00, r[17]}, "chkn");
         chk({7'h00, sysOe}, {7'h00, !r[22]}, "rdoe");
         if (!r[22]) begin
            chk(sysDataOut, r[7:0], "rdata");
         end else begin
            chk(expDataOut, r[31:24], "wdata");
            chk({7'h00, expDataOe}, 8'h01, "wroe");
         end
         @(posedge ref_clk);
         rdN <= 1'b1;
         wrN <= 1'b1;
         sysRefresh <= 1'b0;
      end
      final_report;
   end
endmodule // tb_top
